// file: design/wdr_pkg.sv
package wdr_pkg;

  // register addresses on the cpu data bus
  localparam logic [15:0] ADDR_CFG = 16'hFF98;
  localparam logic [15:0] ADDR_KICK = 16'hFF99;

  // reset values and the restart code
  localparam logic [7:0] CFG_RST = 8'h67;
  localparam logic [7:0] KICK_RST = 8'h9A;
  localparam logic [7:0] KICK_CODE = 8'hAC;

  // config register field layout
  localparam int STOP_BIT = 4;
  localparam int SRC_BIT = 3;
  localparam int INTV_LSB = 0;
  localparam int INTV_W = 3;
  localparam int FIXED_LSB = 5;
  localparam logic [2:0] CFG_FIXED = 3'h3;

  // overflow exponents for interval code zero, per source clock
  localparam int RING_EXP_BASE = 11;
  localparam int X1_EXP_BASE = 13;

  // counter wide enough for the longest interval of either source
  localparam int CNT_W = 21;
  localparam int SHIFT_W = 5;

  // source clock indices inside the synchroniser bank
  localparam int SRC_RING = 0;
  localparam int SRC_X1 = 1;
  localparam int SRC_N = 2;

  // timer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STOPPED = 3'b010,
    ST_FIRED = 3'b100
  } wdr_state_t;

endpackage

// file: design/wdr_edge_sync.sv
`timescale 1ns/1ps
module wdr_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous pin level
  input wire logic pinIn,
  // one-cycle pulse on a confirmed rising edge
  output logic risePulse
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;
  logic rise_q, rise_d;

  // the filtered level only moves once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    rise_d = 1'b0;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
      rise_d = s3_q & ~lvl_q;
    end
  end

  // first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign risePulse = rise_q;

endmodule

// file: design/wdr_watchdog_reset_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - restart code write clears counter, recount
// - reset loads kick register fixed pattern
// - other kick value while running forces reset
// - violation while source halted waits for resume
// - single-bit kick access while running forces reset
// - kick register always reads fixed pattern
// - overflow while running forces reset
// - second config write while running forces reset
// - stopped timer ignores violations, never restarts
// - fixed option forces ring osc, ignores bits
// - after reset count ring osc, longest interval
// - fixed option never halts counting
// - any non-bit-level config write clears counter
// - stoppable option selects ring, X1 or stop
// - stoppable option pauses in idle, sleep
// - after standby resume, counter value kept
// - select bits: 00 ring, 01 X1, 1x stop
// - interval code picks power-of-two overflow
// - config register resets to ring, maximum interval
module wdr_watchdog_reset_timer
  import wdr_pkg::*;
#(
  parameter bit NON_STOPPABLE = 1'b0,
  parameter int RING_EXP = RING_EXP_BASE,
  parameter int X1_EXP = X1_EXP_BASE
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // cpu register bus
  input wire logic [15:0] busAddr,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic busBitOp,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  output logic busRdValid,
  // source clock pins and their status
  input wire logic ringClkIn,
  input wire logic x1ClkIn,
  input wire logic x1Stopped,
  // cpu standby modes
  input wire logic idleMode,
  input wire logic sleepMode,
  // internal reset request, held until srst
  output logic wdtReset
);

  wdr_state_t state_q, state_d;
  logic [7:0] cfg_q, cfg_d;
  logic cfgDone_q, cfgDone_d;
  logic pend_q, pend_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] kickReg_q;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q;
  logic [SRC_N-1:0] srcTick;
  logic [SRC_N-1:0] srcPins;
  logic selStop, selX1, srcHalted, tick, counting;
  logic hitKick, hitCfg, kickWr, kickGood, kickBad, kickBitRd;
  logic cfgWr, cfgSecond, viol, ovf;
  logic [SHIFT_W-1:0] shift;
  logic [CNT_W-1:0] limit;

  // one synchroniser per source clock pin
  assign srcPins[SRC_RING] = ringClkIn;
  assign srcPins[SRC_X1] = x1ClkIn;

  generate
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
      wdr_edge_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pinIn(srcPins[i]),
        .risePulse(srcTick[i])
      );
    end
  endgenerate

  // clock selection; fixed option pins the ring osc
  assign selStop = cfg_q[STOP_BIT] & ~NON_STOPPABLE;
  assign selX1 = cfg_q[SRC_BIT] & ~selStop & ~NON_STOPPABLE;
  assign tick = selX1 ? srcTick[SRC_X1] : srcTick[SRC_RING];

  // standby or a dead X1 starves the counter in the stoppable option
  assign srcHalted = ~NON_STOPPABLE & (idleMode | sleepMode | (selX1 & x1Stopped));
  assign counting = (state_q == ST_RUN) & ~srcHalted & tick;

  // overflow limit is a power of two of the chosen source
  always_comb begin
    shift = selX1 ? SHIFT_W'(X1_EXP) : SHIFT_W'(RING_EXP);
    shift = shift + SHIFT_W'(cfg_q[INTV_LSB +: INTV_W]);
    limit = (CNT_W'(1) << shift) - CNT_W'(1);
  end

  // the edge that finds the counter already at the limit is the overflow
  assign ovf = counting & (cnt_q == limit);

  // bus decode
  assign hitKick = busAddr == ADDR_KICK;
  assign hitCfg = busAddr == ADDR_CFG;
  assign kickWr = busWr & hitKick;
  assign kickGood = kickWr & ~busBitOp & (busWrData == KICK_CODE);
  assign kickBad = kickWr & ~kickGood;
  assign kickBitRd = busRd & hitKick & busBitOp;
  // a bit-level config write is simply not taken
  assign cfgWr = busWr & hitCfg & ~busBitOp;
  assign cfgSecond = cfgWr & cfgDone_q;
  assign viol = kickBad | kickBitRd | cfgSecond;

  // timer state, pending violation and config register
  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    cfg_d = cfg_q;
    cfgDone_d = cfgDone_q;
    case (state_q)
      ST_RUN: begin
        if (srcHalted) begin
          // violation is parked until the source runs again
          if (viol) begin
            pend_d = 1'b1;
          end
        end else if (viol || pend_q || ovf) begin
          state_d = ST_FIRED;
        end
        if (cfgWr && !cfgDone_q) begin
          cfgDone_d = 1'b1;
          if (NON_STOPPABLE) begin
            cfg_d = {CFG_FIXED, 2'h0, busWrData[INTV_LSB +: INTV_W]};
          end else begin
            cfg_d = {CFG_FIXED, busWrData[STOP_BIT:INTV_LSB]};
          end
          // stop wins only if nothing already fired this cycle
          if (!NON_STOPPABLE && busWrData[STOP_BIT] && state_d == ST_RUN) begin
            state_d = ST_STOPPED;
            pend_d = 1'b0;
          end
        end
      end
      ST_STOPPED: begin
        // no way back: clearing the stop bit needs a second write,
        // and that write is itself ignored here
        state_d = ST_STOPPED;
      end
      ST_FIRED: begin
        state_d = ST_FIRED;
      end
      default: begin
        state_d = ST_FIRED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_RUN;
      pend_q <= 1'b0;
      cfg_q <= CFG_RST;
      cfgDone_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      cfg_q <= cfg_d;
      cfgDone_q <= cfgDone_d;
    end
  end

  // counter: clears on a good kick, any non-bit-level config write or an overflow, else counts
  always_comb begin
    cnt_d = cnt_q;
    if (kickGood || cfgWr) begin
      cnt_d = '0;
    end else if (ovf) begin
      cnt_d = '0;
    end else if (counting) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // kick register keeps its reset pattern; writes only act as commands
  always_ff @(posedge clk) begin
    if (srst) begin
      kickReg_q <= KICK_RST;
    end else begin
      kickReg_q <= KICK_RST;
    end
  end

  // read data: registered, valid one cycle after the strobe
  always_comb begin
    rdData_d = rdData_q;
    if (busRd) begin
      if (hitCfg) begin
        rdData_d = cfg_q;
      end else if (hitKick) begin
        rdData_d = kickReg_q;
      end else begin
        rdData_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= busRd;
    end
  end

  assign busRdData = rdData_q;
  assign busRdValid = rdValid_q;
  assign wdtReset = (state_q == ST_FIRED);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_KICK_CLEARS: assert property (
    kickGood && !cfgWr |=> cnt_q == '0)
    else $error("restart code did not clear the counter");

  AST_KICK_READ: assert property (
    busRd && hitKick |=> busRdValid && busRdData == KICK_RST)
    else $error("kick register read returned a wrong value");

  AST_BAD_KICK: assert property (
    state_q == ST_RUN && !srcHalted && kickBad |=> wdtReset)
    else $error("bad kick value did not raise reset");

  AST_BIT_KICK_READ: assert property (
    state_q == ST_RUN && !srcHalted && kickBitRd |=> wdtReset)
    else $error("single-bit kick access did not raise reset");

  AST_SECOND_CFG: assert property (
    state_q == ST_RUN && !srcHalted && cfgSecond |=> wdtReset)
    else $error("second config write did not raise reset");

  AST_HELD_THEN_FIRED: assert property (
    state_q == ST_RUN && srcHalted && viol |=> !wdtReset && pend_q
      ##0 (srcHalted [*1] or (!srcHalted ##1 wdtReset)))
    else $error("held violation not kept or not fired on resume");

  AST_STOP_QUIET: assert property (
    state_q == ST_STOPPED |=> state_q == ST_STOPPED && !wdtReset [*2])
    else $error("stopped timer left stop or raised reset");

  AST_OVERFLOW: assert property (
    ovf |=> wdtReset)
    else $error("overflow did not raise reset");

  AST_FIXED_SOURCE: assert property (
    NON_STOPPABLE |-> cfg_q[STOP_BIT:SRC_BIT] == 2'h0 && !srcHalted)
    else $error("fixed option left the ring osc or halted");

  AST_PAUSE_HOLDS: assert property (
    state_q == ST_RUN && srcHalted && !kickGood && !cfgWr |=> cnt_q == $past(cnt_q))
    else $error("counter moved while paused");

  AST_CFG_CLEARS: assert property (
    cfgWr |=> cnt_q == '0)
    else $error("config write did not clear the counter");

  AST_RESET_STATE: assert property (
    $past(srst) |-> cfg_q == CFG_RST && state_q == ST_RUN && cnt_q == '0)
    else $error("wrong state after reset release");

  AST_COUNT_STEP: assert property (
    counting && !ovf && !kickGood && !cfgWr |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not step on a counted tick");

  AST_X1_IGNORES_RING: assert property (
    selX1 && srcTick[SRC_RING] && !srcTick[SRC_X1] && !kickGood && !cfgWr
      |=> cnt_q == $past(cnt_q))
    else $error("ring tick counted while X1 selected");

  AST_FIXED_NEVER_PAUSES: assert property (
    NON_STOPPABLE && state_q == ST_RUN && tick && (idleMode || sleepMode) |-> counting)
    else $error("fixed option paused in standby");

  AST_STOP_ENTRY: assert property (
    !NON_STOPPABLE && state_q == ST_RUN && !pend_q && !ovf && cfgWr && !cfgDone_q
      && busWrData[STOP_BIT] |=> state_q == ST_STOPPED && !wdtReset)
    else $error("stop bit write did not stop the timer");

  AST_RESUME_KEEPS: assert property (
    state_q == ST_RUN && $fell(srcHalted) && !$past(kickGood) && !$past(cfgWr)
      |-> cnt_q == $past(cnt_q))
    else $error("counter lost its value across standby");

endmodule

// file: sim/wdr_watchdog_reset_timer_tb_top.sv
`timescale 1ns/1ps
module wdr_watchdog_reset_timer_tb_top;
  import wdr_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d; logic b;} wdr_row_t;
  // short exponents keep overflow runs to a few thousand cycles
  localparam int RE = 1;
  localparam int XE = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic busBitOp = 1'b0;
  logic [7:0] busWrData = 8'h00;
  logic ringClkIn = 1'b0;
  logic x1ClkIn = 1'b0;
  logic x1Stopped = 1'b0;
  logic idleMode = 1'b0;
  logic sleepMode = 1'b0;
  logic [7:0] rdA, rdB, got;
  logic vA, vB, rstA, rstB;
  int miscompares = 0;
  int comparisons = 0;
  wdr_row_t rows [3];
  wdr_row_t bad [3];

  always #2 clk = ~clk;

  // stoppable option and fixed option see the same stimulus
  wdr_watchdog_reset_timer #(.NON_STOPPABLE(1'b0), .RING_EXP(RE), .X1_EXP(XE)) dut_u (
    .clk(clk), .srst(srst), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
    .busBitOp(busBitOp), .busWrData(busWrData), .busRdData(rdA), .busRdValid(vA),
    .ringClkIn(ringClkIn), .x1ClkIn(x1ClkIn), .x1Stopped(x1Stopped),
    .idleMode(idleMode), .sleepMode(sleepMode), .wdtReset(rstA));
  wdr_watchdog_reset_timer #(.NON_STOPPABLE(1'b1), .RING_EXP(RE), .X1_EXP(XE)) fix_u (
    .clk(clk), .srst(srst), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
    .busBitOp(busBitOp), .busWrData(busWrData), .busRdData(rdB), .busRdValid(vB),
    .ringClkIn(ringClkIn), .x1ClkIn(x1ClkIn), .x1Stopped(x1Stopped),
    .idleMode(idleMode), .sleepMode(sleepMode), .wdtReset(rstB));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic rsts(input logic a, input logic b);
    settle();
    check("reset stoppable", {7'h00, rstA}, {7'h00, a});
    check("reset fixed", {7'h00, rstB}, {7'h00, b});
  endtask

  task automatic do_reset();
    srst = 1'b1;
    idleMode = 1'b0;
    sleepMode = 1'b0;
    x1Stopped = 1'b0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    busAddr = a;
    busWrData = d;
    busBitOp = b;
    busWr = 1'b1;
    @(negedge clk);
    busWr = 1'b0;
    busBitOp = 1'b0;
    // let an edge pass so a following request never retoggles a strobe at once
    @(negedge clk);
  endtask

  // bounded wait for the read answer
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int i;
    busAddr = a;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    for (i = 0; i < 3 && vA !== 1'b1; i++) @(negedge clk);
    if (vA !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    d = rdA;
    check("valid fixed", {7'h00, vB}, 8'h01);
    @(negedge clk);
  endtask

  // each pin phase lasts 4 cycles, above the 2-cycle minimum
  task automatic ticks(input int n, input logic x1);
    repeat (n) begin
      if (x1) x1ClkIn = 1'b1;
      else ringClkIn = 1'b1;
      repeat (4) @(negedge clk);
      x1ClkIn = 1'b0;
      ringClkIn = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  initial begin
    rows = '{'{ADDR_KICK, KICK_RST, 1'b0}, '{ADDR_CFG, CFG_RST, 1'b0},
      '{16'hFF00, 8'h00, 1'b0}};
    bad = '{'{ADDR_KICK, 8'h55, 1'b0}, '{ADDR_KICK, KICK_CODE, 1'b1},
      '{ADDR_CFG, 8'h60, 1'b0}};
    do_reset();
    // reset values, after a kick as well
    wr(ADDR_KICK, KICK_CODE, 1'b0);
    foreach (rows[i]) begin
      rd(rows[i].a, got);
      check("read stoppable", got, rows[i].d);
      check("read fixed", rdB, rows[i].d);
    end
    rsts(1'b0, 1'b0);
    $display("test reset values done");
    // longest ring interval from reset, kick restarts the count
    ticks(200, 1'b0);
    wr(ADDR_KICK, KICK_CODE, 1'b0);
    ticks((1 << (RE + 7)) - 1, 1'b0);
    rsts(1'b0, 1'b0);
    ticks(1, 1'b0);
    rsts(1'b1, 1'b1);
    $display("test overflow done");
    // bad kick, single-bit kick, second config write
    foreach (bad[i]) begin
      do_reset();
      wr(ADDR_CFG, 8'h63, 1'b0);
      rsts(1'b0, 1'b0);
      wr(bad[i].a, bad[i].d, bad[i].b);
      rsts(1'b1, 1'b1);
    end
    // single-bit read of the kick register
    do_reset();
    busAddr = ADDR_KICK;
    busBitOp = 1'b1;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    busBitOp = 1'b0;
    rsts(1'b1, 1'b1);
    $display("test violations done");
    // x1 source: ring ticks do not count
    do_reset();
    wr(ADDR_CFG, 8'h68, 1'b0);
    ticks(4, 1'b0);
    rsts(1'b0, 1'b1);
    ticks((1 << XE) - 1, 1'b1);
    rsts(1'b0, 1'b1);
    // a dead X1 holds the count
    x1Stopped = 1'b1;
    ticks(2, 1'b1);
    rsts(1'b0, 1'b1);
    x1Stopped = 1'b0;
    ticks(1, 1'b1);
    rsts(1'b1, 1'b1);
    $display("test x1 source done");
    // stop bit: violations ignored, no restart
    do_reset();
    wr(ADDR_CFG, 8'h78, 1'b0);
    rd(ADDR_CFG, got);
    check("cfg stoppable", got, 8'h78);
    check("cfg fixed", rdB, 8'h60);
    wr(ADDR_KICK, 8'h55, 1'b0);
    wr(ADDR_CFG, 8'h60, 1'b0);
    wr(ADDR_KICK, KICK_CODE, 1'b1);
    ticks(8, 1'b0);
    rsts(1'b0, 1'b1);
    $display("test stop done");
    // sleep pauses and keeps the count
    do_reset();
    wr(ADDR_CFG, 8'h61, 1'b0);
    ticks(3, 1'b0);
    sleepMode = 1'b1;
    ticks(3, 1'b0);
    rsts(1'b0, 1'b1);
    sleepMode = 1'b0;
    rsts(1'b0, 1'b1);
    ticks(1, 1'b0);
    rsts(1'b1, 1'b1);
    $display("test sleep done");
    // violation in idle waits for the source to resume
    do_reset();
    wr(ADDR_CFG, 8'h60, 1'b0);
    idleMode = 1'b1;
    wr(ADDR_KICK, 8'h55, 1'b0);
    rsts(1'b0, 1'b1);
    idleMode = 1'b0;
    rsts(1'b1, 1'b1);
    $display("test idle done");
    report_and_stop();
  end
endmodule
